// ### rtl/svp_stage.v
// Behaviour
// R01 - Positive sequence is a third of L1, L2 turned 120, L3 turned 240.
// R02 - Negative sequence is a third of L1, L2 turned 240, L3 turned 120.
// R03 - Inputs are fundamental-frequency voltage values only.
// R04 - Front end delivers fresh values for every channel each 5 ms.
// R05 - Static select picks positive or negative sequence, positive by default.
// R06 - With forcing permitted, status forced to normal, start, trip, blocked.
// R07 - Forced status and magnitude select are static, outside setting groups.
// R08 - Magnitude is compared against the pick-up threshold while running.
// R09 - Over mode releases only below 97 percent of the threshold.
// R10 - Under mode releases only above 103 percent of the threshold.
// R11 - Pick-up when magnitude goes above (over) or below (under) threshold.
// R12 - Direction setting selects over or under, over by default.
// R13 - Threshold in 0.01 percent of nominal steps, default 105 percent.
// R14 - Under blocking level up to 80 percent, default 5, under mode only.
// R15 - Setting changes take effect while the stage keeps running.
// R16 - Sequence magnitudes are scaled to the line-to-line voltage level.
// R17 - Under mode block holds until all line voltages exceed threshold.
// R18 - Block input sampled each cycle; blocked is shown instead of start. The code samples block_i only in a cycle with sample_valid_i.
// R19 - Calculation and comparison once per update, start in same cycle.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "svp_consts.vh"

module svp_stage #(
   parameter W = 16,
   parameter UN_LN_CNT = 16'h4000
) (
   // Clock and reset.
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave.
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Fundamental phase-to-neutral phasors from the front end.
   input wire sample_valid_i,
   input wire signed [W-1:0] l1_re_i,
   input wire signed [W-1:0] l1_im_i,
   input wire signed [W-1:0] l2_re_i,
   input wire signed [W-1:0] l2_im_i,
   input wire signed [W-1:0] l3_re_i,
   input wire signed [W-1:0] l3_im_i,
   // Line-to-line magnitudes in 0.01 percent of nominal.
   input wire [15:0] ll12_mag_i,
   input wire [15:0] ll23_mag_i,
   input wire [15:0] ll31_mag_i,
   // External block from the blocking matrix.
   input wire block_i,
   // Stage outputs.
   output wire [1:0] stage_state_o,
   output wire pickup_o,
   output wire start_o,
   output wire trip_o,
   output wire blocked_o,
   output wire under_blocked_o
);

   localparam SW = W + 3;
   localparam MW = 2 * SW;
   localparam CW = 84;

   reg [`SVP_CTRL_WIDTH-1:0] ctrl_ff;
   reg [15:0] pickup_ff;
   reg [15:0] under_block_level_ff;
   reg ack_ff;
   reg [31:0] dat_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [1:0] calc_ff;
   reg [1:0] nxt_calc;
   reg pickup_ff_q;
   reg nxt_pickup;
   reg under_block_level_hold_ff;
   reg nxt_under_block_level_hold;
   reg start_ff;
   reg trip_ff;
   reg blocked_ff;
   reg [15:0] nxt_pickup_val;
   reg [15:0] nxt_under_block_level_val;
   reg [31:0] wr_word;
   reg [31:0] rd_word;

   wire signed [W:0] l2_a_re;
   wire signed [W:0] l2_a_im;
   wire signed [W:0] l2_a2_re;
   wire signed [W:0] l2_a2_im;
   wire signed [W:0] l3_a_re;
   wire signed [W:0] l3_a_im;
   wire signed [W:0] l3_a2_re;
   wire signed [W:0] l3_a2_im;
   wire signed [SW-1:0] pos_re;
   wire signed [SW-1:0] pos_im;
   wire signed [SW-1:0] neg_re;
   wire signed [SW-1:0] neg_im;
   wire [MW-1:0] mag2;
   wire [CW-1:0] lhs;
   wire [41:0] lin_pick;
   wire [41:0] lin_over;
   wire [41:0] lin_under;
   wire [41:0] lin_blk;
   wire [CW-1:0] rhs_pick;
   wire [CW-1:0] rhs_over;
   wire [CW-1:0] rhs_under;
   wire [CW-1:0] rhs_blk;
   wire [17:0] nom3;
   wire under_mode;
   wire bus_req;
   wire bus_wr;
   wire lines_up;

   // Rotations by a and by a squared for phases two and three.
   svp_rot #(.W(W), .ROT240(0)) u_l2_a (
      .re_i(l2_re_i),
      .im_i(l2_im_i),
      .re_o(l2_a_re),
      .im_o(l2_a_im)
   );
   svp_rot #(.W(W), .ROT240(1)) u_l2_a2 (
      .re_i(l2_re_i),
      .im_i(l2_im_i),
      .re_o(l2_a2_re),
      .im_o(l2_a2_im)
   );
   svp_rot #(.W(W), .ROT240(0)) u_l3_a (
      .re_i(l3_re_i),
      .im_i(l3_im_i),
      .re_o(l3_a_re),
      .im_o(l3_a_im)
   );
   svp_rot #(.W(W), .ROT240(1)) u_l3_a2 (
      .re_i(l3_re_i),
      .im_i(l3_im_i),
      .re_o(l3_a2_re),
      .im_o(l3_a2_im)
   );

   // Sums are three times the sequence phasors; the third goes into scale.
   // Only the fundamental phasors enter the sums. [R03]
   assign pos_re = l1_re_i + l2_a_re + l3_a2_re; // [R01]
   assign pos_im = l1_im_i + l2_a_im + l3_a2_im; // [R01]
   assign neg_re = l1_re_i + l2_a2_re + l3_a_re; // [R02]
   assign neg_im = l1_im_i + l2_a2_im + l3_a_im; // [R02]

   // Squared magnitude of the selected sequence.
   svp_mag2 #(.WI(SW)) u_mag2 (
      .re_i(ctrl_ff[`SVP_CTRL_SEQ_SEL] ? neg_re : pos_re), // [R05]
      .im_i(ctrl_ff[`SVP_CTRL_SEQ_SEL] ? neg_im : pos_im), // [R05]
      .mag2_o(mag2)
   );

   // Both sides squared: magnitude times 10^6 against 3*Un*setting*factor.
   // The nominal count is Un line-to-line over root three.
   assign nom3 = {2'h0, UN_LN_CNT} * 18'h3; // [R16]
   assign lhs = mag2 * `SVP_SCALE_SQ; // [R08]
   assign lin_pick = nom3 * pickup_ff * `SVP_HYS_PICK; // [R13]
   assign lin_over = nom3 * pickup_ff * `SVP_HYS_OVER_REL; // [R09]
   assign lin_under = nom3 * pickup_ff * `SVP_HYS_UNDER_REL; // [R10]
   assign lin_blk = nom3 * under_block_level_ff * `SVP_HYS_PICK; // [R14]
   assign rhs_pick = lin_pick * lin_pick;
   assign rhs_over = lin_over * lin_over;
   assign rhs_under = lin_under * lin_under;
   assign rhs_blk = lin_blk * lin_blk;

   assign under_mode = ctrl_ff[`SVP_CTRL_UNDER]; // [R12]
   assign lines_up = (ll12_mag_i > pickup_ff) && (ll23_mag_i > pickup_ff) &&
      (ll31_mag_i > pickup_ff); // [R17]

   // Pick-up with hysteresis, under block latch and stage state.
   always @* begin
      nxt_pickup = pickup_ff_q;
      nxt_under_block_level_hold = under_block_level_hold_ff;
      nxt_calc = calc_ff;
      if (sample_valid_i) begin // [R19]
         if (!under_mode) begin
            if (!pickup_ff_q) begin
               nxt_pickup = lhs > rhs_pick; // [R11]
            end else begin
               nxt_pickup = !(lhs < rhs_over); // [R09]
            end
            nxt_under_block_level_hold = 1'b0; // [R14]
         end else begin
            if (!pickup_ff_q) begin
               nxt_pickup = lhs < rhs_pick; // [R11]
            end else begin
               nxt_pickup = !(lhs > rhs_under); // [R10]
            end
            if (under_block_level_ff == 16'h0000) begin
               nxt_under_block_level_hold = 1'b0; // [R17]
            end else if (lhs < rhs_blk) begin
               nxt_under_block_level_hold = 1'b1; // [R17]
            end else if (lines_up) begin
               nxt_under_block_level_hold = 1'b0; // [R17]
            end
         end
         if (!nxt_pickup || nxt_under_block_level_hold) begin
            nxt_calc = `SVP_ST_NORMAL; // [R17]
         end else if (block_i) begin
            nxt_calc = `SVP_ST_BLOCKED; // [R18]
         end else begin
            nxt_calc = `SVP_ST_START; // [R19]
         end
      end
      // The measured state is kept apart so that ending a force at once
      // shows the real status again instead of a stale forced one.
      nxt_state = nxt_calc;
      if (ctrl_ff[`SVP_CTRL_FORCE_EN]) begin
         nxt_state = ctrl_ff[`SVP_CTRL_FORCE_HI:`SVP_CTRL_FORCE_LO]; // [R06]
      end
   end

   // Stage registers; outputs decode the next state so they move together.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pickup_ff_q <= 1'b0;
         under_block_level_hold_ff <= 1'b0;
         state_ff <= `SVP_ST_NORMAL;
         calc_ff <= `SVP_ST_NORMAL;
         start_ff <= 1'b0;
         trip_ff <= 1'b0;
         blocked_ff <= 1'b0;
      end else begin
         pickup_ff_q <= nxt_pickup;
         under_block_level_hold_ff <= nxt_under_block_level_hold;
         state_ff <= nxt_state;
         calc_ff <= nxt_calc;
         start_ff <= (nxt_state == `SVP_ST_START); // [R19]
         trip_ff <= (nxt_state == `SVP_ST_TRIP); // [R06]
         blocked_ff <= (nxt_state == `SVP_ST_BLOCKED); // [R18]
      end
   end

   // Bus request decode; a write lands on the edge that sees ack high.
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_wr = bus_req && wb_we_i && ack_ff;

   // Byte lane merge and range clamp of written settings.
   always @* begin
      wr_word = 32'h00000000;
      case (wb_adr_i)
         `SVP_ADR_PICKUP: wr_word = {16'h0000, pickup_ff};
         `SVP_ADR_UNDER_BLOCK_LEVEL: wr_word = {16'h0000, under_block_level_ff};
         default: wr_word = {27'h0000000, ctrl_ff};
      endcase
      if (wb_sel_i[0]) begin
         wr_word[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
         wr_word[15:8] = wb_dat_i[15:8];
      end
      nxt_pickup_val = wr_word[15:0];
      if (nxt_pickup_val < `SVP_PICKUP_MIN) begin
         nxt_pickup_val = `SVP_PICKUP_MIN; // [R13]
      end else if (nxt_pickup_val > `SVP_PICKUP_MAX) begin
         nxt_pickup_val = `SVP_PICKUP_MAX; // [R13]
      end
      nxt_under_block_level_val = wr_word[15:0];
      if (nxt_under_block_level_val > `SVP_UNDER_BLOCK_LEVEL_MAX) begin
         nxt_under_block_level_val = `SVP_UNDER_BLOCK_LEVEL_MAX; // [R14]
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always @* begin
      case (wb_adr_i)
         `SVP_ADR_CTRL: rd_word = {27'h0000000, ctrl_ff};
         `SVP_ADR_PICKUP: rd_word = {16'h0000, pickup_ff};
         `SVP_ADR_UNDER_BLOCK_LEVEL: rd_word = {16'h0000, under_block_level_ff};
         `SVP_ADR_STATUS: rd_word = {26'h0000000, blocked_ff, start_ff,
            under_block_level_hold_ff, pickup_ff_q, state_ff};
         default: rd_word = 32'h00000000;
      endcase
   end

   // Settings are applied live; the force field acts at the next clock, the others are read at the next sample.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `SVP_CTRL_RST;
         pickup_ff <= `SVP_PICKUP_RST;
         under_block_level_ff <= `SVP_UNDER_BLOCK_LEVEL_RST;
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else begin
         ack_ff <= bus_req && !ack_ff;
         if (bus_req && !ack_ff) begin
            dat_ff <= rd_word;
         end
         if (bus_wr) begin
            case (wb_adr_i)
               `SVP_ADR_CTRL: ctrl_ff <= wr_word[`SVP_CTRL_WIDTH-1:0]; // [R07]
               `SVP_ADR_PICKUP: pickup_ff <= nxt_pickup_val; // [R15]
               `SVP_ADR_UNDER_BLOCK_LEVEL: under_block_level_ff <= nxt_under_block_level_val; // [R15]
               default: ctrl_ff <= ctrl_ff;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign stage_state_o = state_ff;
   assign pickup_o = pickup_ff_q;
   assign start_o = start_ff;
   assign trip_o = trip_ff;
   assign blocked_o = blocked_ff;
   assign under_blocked_o = under_block_level_hold_ff;

endmodule // svp_stage

// ### common/svp_consts.vh
`ifndef SVP_CONSTS_VH
`define SVP_CONSTS_VH

// Register byte offsets on the Wishbone slave.
`define SVP_ADR_CTRL 8'h00
`define SVP_ADR_PICKUP 8'h04
`define SVP_ADR_UNDER_BLOCK_LEVEL 8'h08
`define SVP_ADR_STATUS 8'h0c

// Control register field positions.
`define SVP_CTRL_SEQ_SEL 0
`define SVP_CTRL_UNDER 1
`define SVP_CTRL_FORCE_LO 2
`define SVP_CTRL_FORCE_HI 3
`define SVP_CTRL_FORCE_EN 4
`define SVP_CTRL_WIDTH 5

// Stage state codes, also used for the forced state field.
`define SVP_ST_NORMAL 2'h0
`define SVP_ST_START 2'h1
`define SVP_ST_TRIP 2'h2
`define SVP_ST_BLOCKED 2'h3

// Setting limits and reset values in units of 0.01 percent of nominal, except the control word reset value.
`define SVP_PICKUP_RST 16'h2904
`define SVP_PICKUP_MIN 16'h01f4
`define SVP_PICKUP_MAX 16'h3a98
`define SVP_UNDER_BLOCK_LEVEL_RST 16'h01f4
`define SVP_UNDER_BLOCK_LEVEL_MAX 16'h1f40
`define SVP_CTRL_RST 5'h00

// Hysteresis factors in percent of the pick-up threshold.
`define SVP_HYS_PICK 7'h64
`define SVP_HYS_OVER_REL 7'h61
`define SVP_HYS_UNDER_REL 7'h67

// Square of the scale that turns a ratio into 0.0001 percent units.
`define SVP_SCALE_SQ 40'he8d4a51000

// Sine of 60 degrees and one half, both in Q15.
`define SVP_SIN60_Q15 17'sh06eda
`define SVP_HALF_Q15 17'sh04000
`define SVP_Q15_SHIFT 15

`endif

// ### rtl/svp_rot.v
`timescale 1ns/10ps
`include "svp_consts.vh"

// Rotates a phasor by 120 degrees, or by 240 degrees when ROT240 is set.
module svp_rot #(
   parameter W = 16,
   parameter ROT240 = 0
) (
   // Phasor in.
   input wire signed [W-1:0] re_i,
   input wire signed [W-1:0] im_i,
   // Rotated phasor out, one bit wider.
   output wire signed [W:0] re_o,
   output wire signed [W:0] im_o
);

   wire signed [16:0] k_sin = `SVP_SIN60_Q15;
   wire signed [16:0] k_half = `SVP_HALF_Q15;
   wire signed [W+16:0] kx;
   wire signed [W+16:0] ky;
   wire signed [W+16:0] hx;
   wire signed [W+16:0] hy;
   wire signed [W+16:0] re_q;
   wire signed [W+16:0] im_q;

   // Products in Q15 keep the fraction until the final shift.
   assign kx = re_i * k_sin;
   assign ky = im_i * k_sin;
   assign hx = re_i * k_half;
   assign hy = im_i * k_half;

   // Multiplication by cos and sin of the chosen angle.
   assign re_q = (ROT240 != 0) ? (ky - hx) : (-hx - ky);
   assign im_q = (ROT240 != 0) ? (-kx - hy) : (kx - hy);
   assign re_o = re_q[W+`SVP_Q15_SHIFT:`SVP_Q15_SHIFT];
   assign im_o = im_q[W+`SVP_Q15_SHIFT:`SVP_Q15_SHIFT];

endmodule // svp_rot

// ### rtl/svp_mag2.v
`timescale 1ns/10ps

// Squared magnitude of a phasor; comparing squares avoids a square root.
module svp_mag2 #(
   parameter WI = 19
) (
   // Phasor in.
   input wire signed [WI-1:0] re_i,
   input wire signed [WI-1:0] im_i,
   // Squared magnitude out.
   output wire [2*WI-1:0] mag2_o
);

   wire signed [2*WI-1:0] sq_re;
   wire signed [2*WI-1:0] sq_im;

   // Each square is non-negative, so the unsigned sum cannot wrap.
   assign sq_re = re_i * re_i;
   assign sq_im = im_i * im_i;
   assign mag2_o = $unsigned(sq_re) + $unsigned(sq_im);

endmodule // svp_mag2

// ### test/svp_monitor.sv
`timescale 1ns/10ps

// Port checks of the stage, with a mirror of the control word.
module svp_monitor (
   // Clock, reset and bus.
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   // Samples and stage outputs.
   input wire sample_valid_i,
   input wire block_i,
   input wire [1:0] stage_state_o,
   input wire pickup_o,
   input wire start_o,
   input wire trip_o,
   input wire under_blocked_o
);
   reg [4:0] ctrl_ff;

   // Control mirror is taken at each acked write to offset zero.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= 5'h00;
      end else if (wb_cyc_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00) begin
         ctrl_ff <= wb_dat_i[4:0];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   pick_hold_a: assert property (
      $changed(pickup_o) |-> $past(sample_valid_i))
      else $error("pickup moved without a sample");
   start_dec_a: assert property (start_o == (stage_state_o == 2'h1))
      else $error("start does not match state");
   force_state_a: assert property (
      ctrl_ff[4] && $stable(ctrl_ff) |-> stage_state_o == ctrl_ff[3:2])
      else $error("forced state not shown");
   block_start_a: assert property (
      sample_valid_i && block_i && !ctrl_ff[4] |=> !start_o)
      else $error("start while blocked");
   pick_start_a: assert property (
      (sample_valid_i && !block_i && !ctrl_ff[4]) ##1
      (pickup_o && !under_blocked_o) |-> start_o)
      else $error("pickup without start");
   under_norm_a: assert property (
      under_blocked_o && !ctrl_ff[4] && !$past(ctrl_ff[4])
      |-> stage_state_o == 2'h0) else $error("latch not holding normal");
   trip_only_a: assert property (
      trip_o |-> ctrl_ff[4] || $past(ctrl_ff[4]))
      else $error("trip without forcing");

   cover property (sample_valid_i && block_i ##1 stage_state_o == 2'h3);
   cover property (under_blocked_o);
   cover property (ctrl_ff[4] && trip_o);
endmodule // svp_monitor

bind svp_stage svp_monitor i_svp_monitor (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .sample_valid_i,
   .block_i, .stage_state_o, .pickup_o, .start_o, .trip_o, .under_blocked_o);

// ### test/svp_front.sv
`timescale 1ns/10ps

// Front end: a balanced phasor set per update, inverse pattern between.
module svp_front #(
   parameter PERIOD = 8
) (
   // Clock, reset and command.
   input wire clk_i,
   input wire rst_i,
   input wire [15:0] mag_i,
   input wire neg_i,
   // Update strobe, phasors and line magnitude.
   output reg sample_valid_o,
   output reg [15:0] l1_re_o,
   output reg [15:0] l1_im_o,
   output reg [15:0] l2_re_o,
   output reg [15:0] l2_im_o,
   output reg [15:0] l3_re_o,
   output reg [15:0] l3_im_o,
   output reg [15:0] ll_o
);
   reg [7:0] cnt_ff;
   reg [31:0] h;

   // Fundamental values only; reverse rotation gives a negative set.
   always @(posedge clk_i) begin
      h = (mag_i * 32'h00006eda) >> 15;
      if (neg_i) begin
         h = -h;
      end
      cnt_ff <= (rst_i || cnt_ff == PERIOD - 1) ? 8'h00 : cnt_ff + 8'h01;
      sample_valid_o <= !rst_i && cnt_ff == PERIOD - 1;
      if (rst_i || cnt_ff == PERIOD - 1) begin
         l1_re_o <= mag_i;
         l1_im_o <= 16'h0000;
         l2_re_o <= -(mag_i >> 1);
         l2_im_o <= -h[15:0];
         l3_re_o <= -(mag_i >> 1);
         l3_im_o <= h[15:0];
         ll_o <= (mag_i * 32'h00002710) >> 14;
      end else begin
         l1_re_o <= ~l1_re_o;
         l1_im_o <= ~l1_im_o;
         l2_re_o <= ~l2_re_o;
         l2_im_o <= ~l2_im_o;
         l3_re_o <= ~l3_re_o;
         l3_im_o <= ~l3_im_o;
         ll_o <= ~ll_o;
      end
   end
endmodule // svp_front

// ### test/testbench.sv
`timescale 1ns/10ps
`include "svp_consts.vh"

module testbench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg wb_we_i = 1'b0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [31:0] wb_dat_i = 32'h0;
   reg block_i = 1'b0;
   reg [15:0] fe_mag = 16'h0;
   reg fe_neg = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, sample_valid_i, pickup_o, under_blocked_o;
   wire start_o, trip_o, blocked_o;
   wire [15:0] l1_re_i, l1_im_i, l2_re_i, l2_im_i, l3_re_i, l3_im_i, ll;
   wire [1:0] stage_state_o;
   integer n_mismatch = 0, checked = 0, cycles = 0, seed = 78, k;
   reg [31:0] rdata;
   reg [15:0] pu, pct;

   svp_stage i_svp_stage (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .sample_valid_i, .l1_re_i, .l1_im_i, .l2_re_i, .l2_im_i, .l3_re_i,
      .l3_im_i, .ll12_mag_i(ll), .ll23_mag_i(ll), .ll31_mag_i(ll), .block_i,
      .stage_state_o, .pickup_o, .start_o, .trip_o, .blocked_o,
      .under_blocked_o);
   svp_front i_svp_front (.clk_i, .rst_i, .mag_i(fe_mag), .neg_i(fe_neg),
      .sample_valid_o(sample_valid_i), .l1_re_o(l1_re_i), .l1_im_o(l1_im_i),
      .l2_re_o(l2_re_i), .l2_im_o(l2_im_i), .l3_re_o(l3_re_i),
      .l3_im_o(l3_im_i), .ll_o(ll));

   // Clock and a watchdog that ends a hung run.
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         final_report;
      end
   end

   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task final_report;
      begin
         $display("checked %0d n_mismatch %0d", checked, n_mismatch);
         if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask

   // One classic bus cycle, held until ack is sampled.
   task xfer(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1) @(posedge clk_i);
         rdata = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [31:0] e);
      begin
         xfer(a, 1'h0, 32'h0);
         check("register", rdata, e);
      end
   endtask

   // Sets magnitude in 0.01 percent, {negative set, block}; checks
   // {state, pickup, under block} right after the next update.
   task run(input [15:0] p, input [1:0] nb, input [3:0] e);
      begin
         @(posedge clk_i);
         fe_mag <= (p * 32'h4000) / 32'h2710;
         {fe_neg, block_i} <= nb;
         repeat (2) @(posedge clk_i);
         while (sample_valid_i !== 1'b1) @(posedge clk_i);
         @(posedge clk_i);
         check("stage", {stage_state_o, pickup_o, under_blocked_o}, e);
         check("flags", {start_o, trip_o, blocked_o},
            {e[3:2] == `SVP_ST_START, e[3:2] == `SVP_ST_TRIP,
            e[3:2] == `SVP_ST_BLOCKED});
      end
   endtask

   function [1:0] over_state(input [15:0] v, input [15:0] th);
      over_state = (v > th) ? `SVP_ST_START : `SVP_ST_NORMAL;
   endfunction

   // Main sequence: reset values, over, sequence select, under, forcing.
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`SVP_ADR_CTRL, 32'h0);
      rd(`SVP_ADR_PICKUP, 32'h2904);
      rd(`SVP_ADR_UNDER_BLOCK_LEVEL, 32'h1f4);
      rd(8'h10, 32'h0);
      rd(`SVP_ADR_STATUS, 32'h0);
      $display("test reset values ended");
      run(16'h2af8, 2'h0, 4'h6);
      run(16'h283c, 2'h0, 4'h6);
      run(16'h2710, 2'h0, 4'h0);
      run(16'h2af8, 2'h1, 4'he);
      xfer(`SVP_ADR_CTRL, 1'h1, 32'h1);
      run(16'h2af8, 2'h0, 4'h0);
      run(16'h2af8, 2'h2, 4'h6);
      xfer(`SVP_ADR_CTRL, 1'h1, 32'h0);
      run(16'h2af8, 2'h2, 4'h0);
      $display("test over mode ended");
      xfer(`SVP_ADR_CTRL, 1'h1, 32'h2);
      run(16'h2710, 2'h0, 4'h6);
      run(16'h29cc, 2'h0, 4'h6);
      run(16'h2a94, 2'h0, 4'h0);
      run(16'h012c, 2'h0, 4'h3);
      run(16'h283c, 2'h0, 4'h3);
      run(16'h2a94, 2'h0, 4'h0);
      xfer(`SVP_ADR_UNDER_BLOCK_LEVEL, 1'h1, 32'hffff);
      rd(`SVP_ADR_UNDER_BLOCK_LEVEL, 32'h1f40);
      xfer(`SVP_ADR_UNDER_BLOCK_LEVEL, 1'h1, 32'h0);
      run(16'h012c, 2'h0, 4'h6);
      xfer(`SVP_ADR_PICKUP, 1'h1, 32'hffff);
      rd(`SVP_ADR_PICKUP, 32'h3a98);
      $display("test under mode ended");
      for (k = 0; k < 4; k = k + 1) begin
         xfer(`SVP_ADR_CTRL, 1'h1, 32'h10 | (k << 2));
         repeat (2) @(posedge clk_i);
         check("forced", stage_state_o, k);
      end
      xfer(`SVP_ADR_CTRL, 1'h1, 32'h0);
      repeat (2) @(posedge clk_i);
      check("unforced", stage_state_o, `SVP_ST_NORMAL);
      $display("test forcing ended");
      for (k = 0; k < 24; k = k + 1) begin
         pu = 16'h01f4 + {$random(seed)} % 16'h38a5;
         pct = {$random(seed)} % 16'h3e80;
         if (pct + 16'h0028 > pu && pct < pu + 16'h0028) begin
            pct = pu + 16'h0050;
         end
         run(16'h0000, 2'h0, 4'h0);
         xfer(`SVP_ADR_PICKUP, 1'h1, {16'h0, pu});
         run(pct, 2'h0, {over_state(pct, pu), pct > pu, 1'h0});
      end
      $display("test random thresholds ended");
      final_report;
   end
endmodule // testbench
